/* File: inc/scd_defines.vh */
`ifndef SCD_DEFINES_VH
`define SCD_DEFINES_VH
// Opcode bytes
`define SCD_OP_ESC 8'h0f
`define SCD_OP_SETDIR 8'hfd
`define SCD_OP_SH1 7'h68
`define SCD_OP_SHCL 7'h69
`define SCD_OP_SHIMM 7'h60
// Second bytes after the escape
`define SCD_OP2_SETCC_HI 4'h9
`define SCD_OP2_DESC1 8'h01
`define SCD_OP2_DESC0 8'h00
`define SCD_OP2_DLI 8'ha4
`define SCD_OP2_DLC 8'ha5
`define SCD_OP2_DRI 8'hac
`define SCD_OP2_DRC 8'had
`define SCD_OP2_SMENT 8'h38
// Condition codes (low nibble of second byte)
`define SCD_CC_O 4'h0
`define SCD_CC_NO 4'h1
`define SCD_CC_NB 4'h3
`define SCD_CC_NE 4'h5
`define SCD_CC_A 4'h7
`define SCD_CC_S 4'h8
`define SCD_CC_NS 4'h9
`define SCD_CC_PE 4'ha
`define SCD_CC_PO 4'hb
`define SCD_CC_GE 4'hd
`define SCD_CC_GT 4'hf
// ModRM reg field values
`define SCD_REG_0 3'h0
`define SCD_REG_1 3'h1
`define SCD_REG_SHL 3'h4
`define SCD_REG_SHR 3'h5
// Flag positions in the flag vector
`define SCD_F_CF 0
`define SCD_F_PF 2
`define SCD_F_AF 4
`define SCD_F_ZF 6
`define SCD_F_SF 7
`define SCD_F_DF 10
`define SCD_F_OF 11
// Clock counts
`define SCD_CYC_1 7'd1
`define SCD_CYC_2 7'd2
`define SCD_CYC_3 7'd3
`define SCD_CYC_4 7'd4
`define SCD_CYC_6 7'd6
`define SCD_CYC_84 7'd84
// Result classes
`define SCD_K_NONE 4'h0
`define SCD_K_SETCC 4'h1
`define SCD_K_STORE_GLOBAL_TABLE 4'h2
`define SCD_K_STORE_INTERRUPT_TABLE 4'h3
`define SCD_K_STORE_LOCAL_TABLE 4'h4
`define SCD_K_STSK 4'h5
`define SCD_K_STORE_MACHINE_WORD 4'h6
`define SCD_K_SHL 4'h7
`define SCD_K_SHR 4'h8
`define SCD_K_DSHL 4'h9
`define SCD_K_DSHR 4'ha
`define SCD_K_SMENT 4'hb
`define SCD_K_SETDIR 4'hc
`define SCD_K_ILL 4'hf
`endif

/* File: verilog/scd_decode.v */
`include "scd_defines.vh"
// Function
// - set_if_carry_clear stores byte, one clock
// - set_if_unsigned_above stores byte, one clock
// - set_if_nonzero stores byte, one clock
// - set_if_signed_ge stores byte, one clock
// - set_if_signed_gt stores byte, one clock
// - set_if_no_ovf stores byte, one clock
// - set_if_parity_odd stores byte, one clock
// - set_if_positive stores byte, one clock
// - set_if_ovf stores byte, one clock
// - set_if_parity_even stores byte, one clock
// - set_if_negative stores byte, one clock
// - store_global_table takes six clocks, flags kept
// - store_interrupt_table takes six clocks, flags kept
// - store_local_table one clock, protected mode
// - store_task_selector three clocks, protected mode
// - store_machine_word four clocks, flags kept
// - Left shift 1/2/1 clocks, OF by-1 only
// - Right shift two clocks, OF by-1 only
// - double_left_shift three or six clocks
// - double_right_shift three or six clocks
// - software_sysmgmt_entry takes 84 clocks
// - set_direction set_if_negative DF, four clocks
module scd_decode (
   input wire clk,
   input wire arst_n,
   input wire op_valid,
   output wire op_ready,
   input wire [7:0] op_byte0,
   input wire [7:0] op_byte1,
   input wire [7:0] op_modrm,
   input wire prot_mode,
   input wire [11:0] flags_in,
   output reg done,
   output reg [3:0] kind,
   output reg [7:0] cond_byte,
   output reg [11:0] flags_out,
   output reg [11:0] flags_undef,
   output reg flags_we,
   output reg illegal,
   output reg busy
);

   reg [6:0] count; // Cycles left in current instruction
   reg [3:0] next_kind; // Decoded class
   reg [6:0] next_cycles; // Decoded clock count
   reg [7:0] next_cond; // Condition byte
   reg [11:0] next_flags; // Flag result
   reg [11:0] next_undef; // Undefined flag mask
   reg next_we; // Flag write
   reg cc_true; // Condition result
   wire [3:0] cc; // Condition nibble
   wire [2:0] reg_f; // ModRM reg field
   wire cf;
   wire pf;
   wire zf;
   wire sf;
   wire of;

   // Opcode group strobes
   reg cc_known; // Condition code is one of ours
   wire sh_by1; // Shift by one form
   wire sh_cl; // Shift by count register form
   wire sh_imm; // Shift by immediate form
   wire sh_any; // Any single shift form
   wire esc; // Two byte opcode
   wire dbl_shift; // Double shift second byte
   wire dbl_cl; // Double shift uses count register
   wire desc1; // Table store group, second byte 01
   wire desc0; // Selector store group, second byte 00
   wire sm_entry; // Software system management entry

   assign cc = op_byte1[3:0];
   assign reg_f = op_modrm[5:3];
   assign cf = flags_in[`SCD_F_CF];
   assign pf = flags_in[`SCD_F_PF];
   assign zf = flags_in[`SCD_F_ZF];
   assign sf = flags_in[`SCD_F_SF];
   assign of = flags_in[`SCD_F_OF];
   // Ready when idle
   assign op_ready = ~busy;

   // Timing model of this slice:
   // - an instruction of N clocks is taken on one rising edge
   // - done pulses for one cycle after the edge N-1 clocks later
   // - op_ready stays low in between, so the fetch side holds its
   //   next offer until the current instruction has finished
   // - single clock instructions may follow each other back to back
   // Flag handling:
   // - shifter flag values are not produced here
   // - flags_out carries the incoming flags, with DF forced for
   //   set_direction
   // - flags_we marks the instructions that write flags
   // - flags_undef names the bits those instructions leave undefined
   // Unknown encodings finish in one clock with illegal raised.

   // Single shift forms differ in opcode bits 7:1
   assign sh_by1 = (op_byte0[7:1] == `SCD_OP_SH1);
   assign sh_cl = (op_byte0[7:1] == `SCD_OP_SHCL);
   assign sh_imm = (op_byte0[7:1] == `SCD_OP_SHIMM);
   assign sh_any = sh_by1 | sh_cl | sh_imm;
   assign esc = (op_byte0 == `SCD_OP_ESC);
   // Both double shift pairs differ only in bits 3 and 0
   assign dbl_shift = (op_byte1 == `SCD_OP2_DLI) | (op_byte1 == `SCD_OP2_DLC) |
                      (op_byte1 == `SCD_OP2_DRI) | (op_byte1 == `SCD_OP2_DRC);
   assign dbl_cl = op_byte1[0];
   // Two byte group selects
   assign desc1 = (op_byte1 == `SCD_OP2_DESC1);
   assign desc0 = (op_byte1 == `SCD_OP2_DESC0);
   assign sm_entry = (op_byte1 == `SCD_OP2_SMENT);

   // Which condition nibbles this slice decodes; the rest stay illegal
   always @* begin
      case (cc)
         `SCD_CC_O: cc_known = 1'b1; // Overflow
         `SCD_CC_NO: cc_known = 1'b1; // No overflow
         `SCD_CC_NB: cc_known = 1'b1; // Carry clear
         `SCD_CC_NE: cc_known = 1'b1; // Not zero
         `SCD_CC_A: cc_known = 1'b1; // Unsigned above
         `SCD_CC_S: cc_known = 1'b1; // Negative
         `SCD_CC_NS: cc_known = 1'b1; // Positive
         `SCD_CC_PE: cc_known = 1'b1; // Parity even
         `SCD_CC_PO: cc_known = 1'b1; // Parity odd
         `SCD_CC_GE: cc_known = 1'b1; // Signed greater or equal
         `SCD_CC_GT: cc_known = 1'b1; // Signed greater
         default: cc_known = 1'b0; // Below, equal and the rest
      endcase
   end

   // Condition evaluation
   // Each nibble tests the flags presented with the opcode
   always @* begin
      case (cc)
         `SCD_CC_O: cc_true = of;
         `SCD_CC_NO: cc_true = ~of;
         `SCD_CC_NB: cc_true = ~cf;
         `SCD_CC_NE: cc_true = ~zf;
         `SCD_CC_A: cc_true = ~cf & ~zf;
         `SCD_CC_S: cc_true = sf;
         `SCD_CC_NS: cc_true = ~sf;
         `SCD_CC_PE: cc_true = pf;
         `SCD_CC_PO: cc_true = ~pf;
         `SCD_CC_GE: cc_true = (sf == of);
         `SCD_CC_GT: cc_true = ~zf & (sf == of);
         default: cc_true = 1'b0;
      endcase
   end

   // Decode class, clock count and flag effect
   always @* begin
      // Defaults: unknown encoding, one clock, flags passed through
      next_kind = `SCD_K_ILL;
      next_cycles = `SCD_CYC_1;
      next_cond = 8'h00;
      next_flags = flags_in;
      next_undef = 12'h000;
      next_we = 1'b0;
      if (op_byte0 == `SCD_OP_SETDIR) begin
         // Set direction, others kept
         next_kind = `SCD_K_SETDIR;
         next_cycles = `SCD_CYC_4;
         next_flags[`SCD_F_DF] = 1'b1;
         next_we = 1'b1;
      end else if (sh_any) begin
         // Single shifts: result flags come from the ALU, marked writable
         next_we = 1'b1;
         // Auxiliary carry is never defined by a shift
         next_undef[`SCD_F_AF] = 1'b1;
         // Overflow only defined for the by-one form
         if (!sh_by1) begin
            next_undef[`SCD_F_OF] = 1'b1;
         end
         if (reg_f == `SCD_REG_SHL) begin
            // Left: count register form is the slow one
            next_kind = `SCD_K_SHL;
            if (sh_cl) begin
               next_cycles = `SCD_CYC_2;
            end else begin
               next_cycles = `SCD_CYC_1;
            end
         end else if (reg_f == `SCD_REG_SHR) begin
            // Right: two clocks in every form
            next_kind = `SCD_K_SHR;
            next_cycles = `SCD_CYC_2;
         end else begin
            // Other shift groups are not handled here
            next_we = 1'b0;
            next_undef = 12'h000;
         end
      end else if (esc) begin
         // Two byte opcodes, selected by the second byte
         if (op_byte1[7:4] == `SCD_OP2_SETCC_HI && reg_f == `SCD_REG_0 && cc_known) begin
            // Set byte, flags untouched
            next_kind = `SCD_K_SETCC;
            next_cycles = `SCD_CYC_1;
            next_cond = cc_true ? 8'h01 : 8'h00;
         end else if (desc1) begin
            // Table stores and machine word, by reg field
            if (reg_f == `SCD_REG_0) begin
               next_kind = `SCD_K_STORE_GLOBAL_TABLE;
               next_cycles = `SCD_CYC_6;
            end else if (reg_f == `SCD_REG_1) begin
               next_kind = `SCD_K_STORE_INTERRUPT_TABLE;
               next_cycles = `SCD_CYC_6;
            end else if (reg_f == `SCD_REG_SHL) begin
               next_kind = `SCD_K_STORE_MACHINE_WORD;
               next_cycles = `SCD_CYC_4;
            end
         end else if (desc0 && prot_mode) begin
            // No real-mode form; real mode stays illegal
            if (reg_f == `SCD_REG_0) begin
               next_kind = `SCD_K_STORE_LOCAL_TABLE;
               next_cycles = `SCD_CYC_1;
            end else if (reg_f == `SCD_REG_1) begin
               next_kind = `SCD_K_STSK;
               next_cycles = `SCD_CYC_3;
            end
         end else if (dbl_shift) begin
            // Double shifts: OF and AF undefined
            if (op_byte1[3]) begin
               next_kind = `SCD_K_DSHR;
            end else begin
               next_kind = `SCD_K_DSHL;
            end
            if (dbl_cl) begin
               next_cycles = `SCD_CYC_6;
            end else begin
               next_cycles = `SCD_CYC_3;
            end
            next_we = 1'b1;
            next_undef[`SCD_F_AF] = 1'b1;
            next_undef[`SCD_F_OF] = 1'b1;
         end else if (sm_entry) begin
            // Long fixed entry sequence
            next_kind = `SCD_K_SMENT;
            next_cycles = `SCD_CYC_84;
         end
      end
      // Unknown encodings: one clock, no flag write
      if (next_kind == `SCD_K_ILL) begin
         next_cycles = `SCD_CYC_1;
         next_we = 1'b0;
         next_undef = 12'h000;
         next_flags = flags_in;
      end
   end

   // Latch decode, count clocks, pulse done on the last
   // The decode result is captured at the take edge and held until
   // the next take, so the execute side may read it at any point.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         // Idle, nothing decoded, ready for the first offer
         count <= 7'd0;
         busy <= 1'b0;
         done <= 1'b0;
         kind <= `SCD_K_NONE;
         cond_byte <= 8'h00;
         flags_out <= 12'h000;
         flags_undef <= 12'h000;
         flags_we <= 1'b0;
         illegal <= 1'b0;
      end else begin
         // Completion is a single cycle pulse
         done <= 1'b0;
         if (!busy && op_valid) begin
            // Accept: finish after next_cycles clocks
            kind <= next_kind;
            cond_byte <= next_cond;
            flags_out <= next_flags;
            flags_undef <= next_undef;
            flags_we <= next_we;
            illegal <= (next_kind == `SCD_K_ILL);
            if (next_cycles == `SCD_CYC_1) begin
               // Single clock: done right after the take edge
               done <= 1'b1;
            end else begin
               // Longer: stall the fetch side for the remaining clocks
               busy <= 1'b1;
               count <= next_cycles - `SCD_CYC_1;
            end
         end else if (busy) begin
            // Counting down the remaining clocks
            count <= count - 7'd1;
            if (count == 7'd1) begin
               // Last clock: release the stall and report
               busy <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end

endmodule

/* File: dv/scd_chk_sva.sv */
module scd_chk (
   input wire clk,
   input wire arst_n,
   input wire op_valid,
   input wire op_ready,
   input wire [7:0] op_byte0,
   input wire [7:0] op_byte1,
   input wire [7:0] op_modrm,
   input wire prot_mode,
   input wire [11:0] flags_in,
   input wire done,
   input wire [3:0] kind,
   input wire [7:0] cond_byte,
   input wire [11:0] flags_out,
   input wire [11:0] flags_undef,
   input wire flags_we
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Taken request, escape form and reg field
   wire take = op_valid && op_ready;
   wire esc = take && op_byte0 == 8'h0f;
   wire [2:0] rf = op_modrm[5:3];
   a_setcc_one_clk: assert property (esc && op_byte1[7:4] == 4'h9 && rf == 3'h0
      && (op_byte1[0] || op_byte1[3:0] == 4'h0 || op_byte1[3:0] == 4'h8
      || op_byte1[3:0] == 4'ha)
      |=> done && kind == 4'h1 && flags_out == $past(flags_in) && !flags_we) else $error("set byte");
   a_carry_clear_val: assert property (esc && op_byte1 == 8'h93 && rf == 3'h0
      |=> cond_byte == {7'h00, ~$past(flags_in[0])}) else $error("carry clear value");
   a_nonzero_val: assert property (esc && op_byte1 == 8'h95 && rf == 3'h0
      |=> cond_byte == {7'h00, ~$past(flags_in[6])}) else $error("nonzero value");
   a_global_six: assert property (esc && op_byte1 == 8'h01 && rf == 3'h0
      |=> !done [*5] ##1 done) else $error("global table timing");
   a_intr_six: assert property (esc && op_byte1 == 8'h01 && rf == 3'h1
      |=> !done [*5] ##1 done) else $error("interrupt table timing");
   a_mach_word_four: assert property (esc && op_byte1 == 8'h01 && rf == 3'h4
      |=> !done [*3] ##1 done) else $error("machine word timing");
   a_task_sel_three: assert property (esc && op_byte1 == 8'h00 && rf == 3'h1 && prot_mode
      |=> !done ##1 !done ##1 done) else $error("task selector timing");
   a_sysmgmt_84: assert property (esc && op_byte1 == 8'h38 |-> ##84 done)
      else $error("sysmgmt timing");
   a_setdir_four: assert property (take && op_byte0 == 8'hfd
      |=> !done [*3] ##1 (done && flags_out[10] && flags_we)) else $error("set direction");
   a_left_by_one: assert property (take && op_byte0[7:1] == 7'h68 && rf == 3'h4
      |=> done && !flags_undef[11] && flags_undef[4]) else $error("left shift by one");
   a_right_two: assert property (take && op_byte0[7:2] == 6'h34 && rf == 3'h5
      |=> !done ##1 done) else $error("right shift timing");
   a_dbl_left_six: assert property (esc && op_byte1 == 8'ha5
      |=> !done [*5] ##1 done) else $error("double left timing");
   c_setdir: cover property (take && op_byte0 == 8'hfd);
   c_sysmgmt: cover property (esc && op_byte1 == 8'h38);
   c_setcc: cover property (done && kind == 4'h1);
endmodule
bind scd_decode scd_chk u_chk (.*);

/* File: dv/scd_fetch.sv */
module scd_fetch (
   input wire clk,
   input wire arst_n,
   input wire go,
   input wire [23:0] word,
   input wire op_ready,
   output logic op_valid,
   output logic [23:0] bytes
);
   timeunit 1ns;
   timeprecision 1ns;
   // Offers one triple, holds it until taken, then shows the inverse
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         op_valid <= 1'b0;
         bytes <= 24'h000000;
      end else if (op_valid && op_ready) begin
         op_valid <= 1'b0;
         bytes <= ~bytes;
      end else if (go && !op_valid) begin
         op_valid <= 1'b1;
         bytes <= word;
      end
   end
endmodule

/* File: dv/tb.sv */
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic go = 1'b0;
   logic [23:0] word = 24'h000000;
   logic prot_mode = 1'b0;
   logic [11:0] flags_in = 12'h000;
   wire op_valid, op_ready, done, flags_we, illegal, busy;
   wire [7:0] op_byte0, op_byte1, op_modrm, cond_byte;
   wire [3:0] kind;
   wire [11:0] flags_out, flags_undef;
   int n_fail = 0;
   int check_count = 0;
   // Free running clock
   initial begin
      forever #50 clk = ~clk;
   end
   scd_fetch u_fetch (.clk(clk), .arst_n(arst_n), .go(go), .word(word), .op_ready(op_ready),
      .op_valid(op_valid), .bytes({op_byte0, op_byte1, op_modrm}));
   scd_decode dut (.clk(clk), .arst_n(arst_n), .op_valid(op_valid), .op_ready(op_ready),
      .op_byte0(op_byte0), .op_byte1(op_byte1), .op_modrm(op_modrm), .prot_mode(prot_mode),
      .flags_in(flags_in), .done(done), .kind(kind), .cond_byte(cond_byte),
      .flags_out(flags_out), .flags_undef(flags_undef), .flags_we(flags_we),
      .illegal(illegal), .busy(busy));
   task check(input logic [11:0] seen, input logic [11:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Issues one instruction, counts edges from take to done
   task run(input logic [23:0] w, input int n, input logic [3:0] k);
      int cnt;
      cnt = 0;
      @(posedge clk) go <= 1'b1;
      word <= w;
      @(posedge clk) go <= 1'b0;
      do begin
         @(posedge clk);
         #1 cnt++;
         if (cnt == 1) check(busy, n > 1);
      end while (done !== 1'b1 && cnt < 200);
      if (cnt >= 200) begin
         n_fail++;
         tally_and_finish;
      end
      check(op_ready, 1'b1);
      check(cnt[11:0], n[11:0]);
      check(kind, k);
   endtask
   // Expected condition from the flag vector
   function automatic logic cc(input logic [3:0] c, input logic [11:0] f);
      case (c)
         4'h0: return f[11];
         4'h1: return !f[11];
         4'h3: return !f[0];
         4'h5: return !f[6];
         4'h7: return !f[0] && !f[6];
         4'h8: return f[7];
         4'h9: return !f[7];
         4'ha: return f[2];
         4'hb: return !f[2];
         4'hd: return f[7] == f[11];
         default: return !f[6] && (f[7] == f[11]);
      endcase
   endfunction
   task t_setcc;
      logic [3:0] c;
      logic [11:0] f;
      for (int j = 0; j < 3; j++) begin
         for (int i = 0; i < 11; i++) begin
            c = 4'(44'h0135789abdf >> (4 * i));
            f = 12'(36'h0008c5080 >> (12 * j));
            @(posedge clk) flags_in <= f;
            run({8'h0f, 4'h9, c, 8'h00}, 1, 4'h1);
            check(cond_byte, {7'h00, cc(c, f)});
            check(flags_out, f);
            check(flags_we, 1'b0);
         end
      end
      $display("test setcc done");
   endtask
   task t_desc;
      @(posedge clk) prot_mode <= 1'b1;
      run(24'h0f0100, 6, 4'h2);
      run(24'h0f0108, 6, 4'h3);
      run(24'h0f0120, 4, 4'h6);
      run(24'h0f0000, 1, 4'h4);
      run(24'h0f0008, 3, 4'h5);
      check(flags_we, 1'b0);
      $display("test desc done");
   endtask
   task t_shift;
      run(24'hd10020, 1, 4'h7);
      check(flags_undef[11], 1'b0);
      run(24'hd30020, 2, 4'h7);
      check(flags_undef[11], 1'b1);
      run(24'hc10020, 1, 4'h7);
      run(24'hd10028, 2, 4'h8);
      check(flags_undef[11], 1'b0);
      run(24'hd30028, 2, 4'h8);
      run(24'hc10028, 2, 4'h8);
      check(flags_we, 1'b1);
      run(24'h0fa400, 3, 4'h9);
      run(24'h0fa500, 6, 4'h9);
      run(24'h0fac00, 3, 4'ha);
      run(24'h0fad00, 6, 4'ha);
      check(flags_undef[11], 1'b1);
      $display("test shift done");
   endtask
   task t_misc;
      run(24'h0f3800, 84, 4'hb);
      check(flags_out, flags_in);
      run(24'hfd0000, 4, 4'hc);
      check(flags_out, flags_in | 12'h400);
      @(posedge clk) prot_mode <= 1'b0;
      run(24'h0f0000, 1, 4'hf);
      check(illegal, 1'b1);
      $display("test misc done");
   endtask
   // Reset in mid-instruction returns the block to idle
   task t_reset;
      @(posedge clk) go <= 1'b1;
      word <= 24'h0f3800;
      @(posedge clk) go <= 1'b0;
      repeat (10) @(posedge clk);
      arst_n <= 1'b0;
      @(posedge clk);
      #1 check(busy, 1'b0);
      check(kind, 4'h0);
      check(op_ready, 1'b1);
      check(done, 1'b0);
      @(posedge clk) arst_n <= 1'b1;
      run(24'hfd0000, 4, 4'hc);
      $display("test reset done");
   endtask
   // Reset, then every scenario in turn
   initial begin
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      t_setcc;
      t_desc;
      t_shift;
      t_misc;
      t_reset;
      tally_and_finish;
   end
endmodule
